// *** design/flag_bank.sv ***
`timescale 1ns/100ps
// Sticky flags with clear on read and a masked summary.
module flag_bank (
  input wire logic clk,
  input wire logic rst_n,
  flag_if.bank f
);
  logic [sideband_pkg::NUM_FLAGS-1:0] next_flags;

  // Per flag, a set in the clearing cycle wins so no event is lost.
  genvar i;
  generate
    for (i = 0; i < sideband_pkg::NUM_FLAGS; i++) begin : g_flag
      always_comb begin
        next_flags[i] = f.set_req[i] | (f.flags[i] & ~f.clear_req[i]);
      end
    end
  endgenerate

  // Summary of set flags whose mask is clear.
  always_comb begin
    f.pending = |(f.flags & ~f.mask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f.flags <= sideband_pkg::FLAGS_RESET;
    end else begin
      f.flags <= next_flags;
    end
  end
endmodule : flag_bank

// *** design/mgmt_sideband.sv ***
`timescale 1ns/100ps
// Management sideband of a pluggable module: init sequencing, flags and
// attention, dual-mode pins and power class control.
module mgmt_sideband #(
  parameter int INIT_CYCLES = sideband_pkg::INIT_TIME_CYC,
  parameter int WAKE_CYCLES = sideband_pkg::WAKE_TIME_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_reset_n,
  input wire logic low_power_request,
  input wire logic input_mode_transmit_disable,
  input wire logic output_mode_los,
  input wire logic [sideband_pkg::NUM_FLAGS-1:0] flag_condition,
  input wire logic [sideband_pkg::NUM_FLAGS-1:0] flag_read_clear,
  input wire logic [sideband_pkg::NUM_FLAGS-1:0] flag_mask,
  input wire logic power_override,
  input wire logic power_set,
  output logic attention_out_n,
  output logic receive_loss_out_n,
  output logic transmit_disable,
  output logic management_init_state,
  output logic serial_bus_ready,
  output logic data_not_ready,
  output logic [sideband_pkg::NUM_FLAGS-1:0] flags,
  output logic low_power_active,
  output logic fully_functional
);

  // Counter loads cut from the integer parameters.
  localparam logic [sideband_pkg::CNT_W-1:0] INIT_LOAD =
    sideband_pkg::CNT_W'(INIT_CYCLES);
  localparam logic [sideband_pkg::CNT_W-1:0] WAKE_LOAD =
    sideband_pkg::CNT_W'(WAKE_CYCLES);

  // Raw and synchronised pin levels.
  logic [1:0] pin_raw;
  logic [1:0] pin_sync_q;
  logic reset_pin;
  logic lp_pin;

  // Init sequencer state.
  sideband_pkg::init_e init_state;
  sideband_pkg::init_e next_init_state;
  logic [sideband_pkg::CNT_W-1:0] init_cnt;
  logic [sideband_pkg::CNT_W-1:0] next_init_cnt;
  logic init_done_pulse;

  // Power state.
  sideband_pkg::power_e pwr_state;
  sideband_pkg::power_e next_pwr_state;
  logic [sideband_pkg::CNT_W-1:0] wake_cnt;
  logic [sideband_pkg::CNT_W-1:0] next_wake_cnt;
  logic want_low;

  // Registered mode selects.
  logic mode_transmit_disable;
  logic mode_los;
  logic next_mode_transmit_disable;
  logic next_mode_los;

  // Output next values.
  logic next_attention_out_n;
  logic next_receive_loss_out_n;
  logic next_transmit_disable;
  logic next_management_init_state;
  logic next_serial_bus_ready;
  logic next_data_not_ready;
  logic [sideband_pkg::NUM_FLAGS-1:0] next_flags_out;
  logic next_low_power_active;
  logic next_fully_functional;

  flag_if fl ();

  // Both host pins cross from outside the clock domain. The reset pin
  // idles high and the low-power pin idles low.
  always_comb begin
    pin_raw = {low_power_request, host_reset_n};
  end

  pin_sync #(
    .W(2),
    .RST_VAL(sideband_pkg::PIN_RESET_VAL)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pin_raw),
    .q(pin_sync_q)
  );

  always_comb begin
    reset_pin = pin_sync_q[0];
    lp_pin = pin_sync_q[1];
  end

  // Init sequencer. A synchronised low on the reset pin holds the init state in
  // st_hold; the synchroniser needs two agreeing samples, so a pulse of
  // the guaranteed width always lands while shorter ones may be lost.
  always_comb begin
    next_init_state = init_state;
    next_init_cnt = init_cnt;
    init_done_pulse = 1'b0;
    unique case (init_state)
      sideband_pkg::st_hold: begin
        next_init_cnt = INIT_LOAD;
        if (reset_pin) begin
          next_init_state = sideband_pkg::st_init;
        end
      end
      sideband_pkg::st_init: begin
        if (!reset_pin) begin
          next_init_state = sideband_pkg::st_hold;
        end else if (init_cnt <= sideband_pkg::CNT_ONE) begin
          next_init_state = sideband_pkg::st_run;
          next_init_cnt = sideband_pkg::CNT_ZERO;
          init_done_pulse = 1'b1;
        end else begin
          next_init_cnt = init_cnt - sideband_pkg::CNT_ONE;
        end
      end
      sideband_pkg::st_run: begin
        if (!reset_pin) begin
          next_init_state = sideband_pkg::st_hold;
        end
      end
    endcase
  end

  // Power on and hot plug both come in as the block reset and start
  // the init count at once.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_state <= sideband_pkg::st_init;
      init_cnt <= INIT_LOAD;
    end else begin
      init_state <= next_init_state;
      init_cnt <= next_init_cnt;
    end
  end

  // Mode selects are taken in one cycle, far inside the switch limit.
  always_comb begin
    next_mode_transmit_disable = input_mode_transmit_disable;
    next_mode_los = output_mode_los;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_transmit_disable <= 1'b0;
      mode_los <= 1'b0;
    end else begin
      mode_transmit_disable <= next_mode_transmit_disable;
      mode_los <= next_mode_los;
    end
  end

  // Low power is asked for by the pin in its low-power mode or by
  // either software bit. In transmit-disable mode the pin has no say
  // over power.
  always_comb begin
    want_low = (lp_pin & ~mode_transmit_disable)
      | power_override | power_set;
  end

  // Power sequencer. Dropping to class 1 is immediate; going back up
  // waits the wake count so the rails settle before full function is
  // claimed, a trade of latency for a clean power step.
  always_comb begin
    next_pwr_state = pwr_state;
    next_wake_cnt = wake_cnt;
    unique case (pwr_state)
      sideband_pkg::pwr_low: begin
        next_wake_cnt = WAKE_LOAD;
        if (!want_low) begin
          next_pwr_state = sideband_pkg::pwr_wake;
        end
      end
      sideband_pkg::pwr_wake: begin
        if (want_low) begin
          next_pwr_state = sideband_pkg::pwr_low;
        end else if (wake_cnt <= sideband_pkg::CNT_ONE) begin
          next_pwr_state = sideband_pkg::pwr_full;
          next_wake_cnt = sideband_pkg::CNT_ZERO;
        end else begin
          next_wake_cnt = wake_cnt - sideband_pkg::CNT_ONE;
        end
      end
      sideband_pkg::pwr_full: begin
        if (want_low) begin
          next_pwr_state = sideband_pkg::pwr_low;
        end
      end
    endcase
  end

  // Starting in full power keeps the 2 s budget when the pin is low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_state <= sideband_pkg::pwr_full;
      wake_cnt <= sideband_pkg::CNT_ZERO;
    end else begin
      pwr_state <= next_pwr_state;
      wake_cnt <= next_wake_cnt;
    end
  end

  // Flag bank hookup. Flags set only once init is done, and the
  // data-ready flag is raised by the init completion itself.
  always_comb begin
    fl.set_req = (init_state == sideband_pkg::st_run) ?
      flag_condition : sideband_pkg::FLAGS_RESET;
    fl.set_req[sideband_pkg::FLAG_DATA_READY] =
      init_done_pulse
      | ((init_state == sideband_pkg::st_run)
         & flag_condition[sideband_pkg::FLAG_DATA_READY]);
    fl.clear_req = flag_read_clear;
    fl.mask = flag_mask;
  end

  flag_bank u_flag_bank (
    .clk(clk),
    .rst_n(rst_n),
    .f(fl.bank)
  );

  // Output values. The dual output pin carries attention or the live
  // receive-loss state; the unused name idles high.
  always_comb begin
    next_attention_out_n = ~(fl.pending & ~mode_los);
    next_receive_loss_out_n =
      ~(flag_condition[sideband_pkg::FLAG_RX_LOSS] & mode_los);
    next_transmit_disable = lp_pin & mode_transmit_disable;
    next_management_init_state = (init_state != sideband_pkg::st_run);
    next_serial_bus_ready = (init_state == sideband_pkg::st_run);
    next_data_not_ready = (init_state != sideband_pkg::st_run);
    next_flags_out = fl.flags;
    next_low_power_active = (pwr_state != sideband_pkg::pwr_full);
    next_fully_functional = (init_state == sideband_pkg::st_run)
      & (pwr_state == sideband_pkg::pwr_full);
  end

  // Every output is a flip-flop, adding one cycle of latency that is
  // negligible against any limit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      attention_out_n <= 1'b1;
      receive_loss_out_n <= 1'b1;
      transmit_disable <= 1'b0;
      management_init_state <= 1'b1;
      serial_bus_ready <= 1'b0;
      data_not_ready <= 1'b1;
      flags <= sideband_pkg::FLAGS_RESET;
      low_power_active <= 1'b0;
      fully_functional <= 1'b0;
    end else begin
      attention_out_n <= next_attention_out_n;
      receive_loss_out_n <= next_receive_loss_out_n;
      transmit_disable <= next_transmit_disable;
      management_init_state <= next_management_init_state;
      serial_bus_ready <= next_serial_bus_ready;
      data_not_ready <= next_data_not_ready;
      flags <= next_flags_out;
      low_power_active <= next_low_power_active;
      fully_functional <= next_fully_functional;
    end
  end

endmodule : mgmt_sideband

// *** design/pin_sync.sv ***
`timescale 1ns/100ps
// Three-stage pin synchroniser; a change is taken once stages two and
// three agree, which also rejects a one-cycle glitch.
module pin_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  // Stage one feeds only stage two. Agreement is judged per bit, so a
  // pin that keeps moving cannot hold back a change on its neighbour.
  always_comb begin
    next_q = (s3 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q <= RST_VAL;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule : pin_sync

// *** inc/flag_if.sv ***
`timescale 1ns/100ps
// Signals between the top and its flag bank.
interface flag_if;
  logic [sideband_pkg::NUM_FLAGS-1:0] set_req;
  logic [sideband_pkg::NUM_FLAGS-1:0] clear_req;
  logic [sideband_pkg::NUM_FLAGS-1:0] mask;
  logic [sideband_pkg::NUM_FLAGS-1:0] flags;
  logic pending;

  modport bank (
    input set_req,
    input clear_req,
    input mask,
    output flags,
    output pending
  );

  modport ctrl (
    output set_req,
    output clear_req,
    output mask,
    input flags,
    input pending
  );
endinterface : flag_if

// *** inc/sideband_pkg.sv ***
// Functional notes
// - Finish management init within 2000 ms.
// - Attention goes low within 200 ms.
// - Read clears flag; attention releases within 500 us.
// - Receive loss sets flag, attention, within 100 ms.
// - Any condition sets flag, attention, within 200 ms.
// - Set mask stops flag's attention within 100 ms.
// - Cleared mask restores flag's attention within 100 ms.
// - Serial bus answers within 2 s of power.
// - Data-not-ready clears, attention low, within 2 s.
// - Fully functional within 2 s of reset release.
// - 2 s full function with low power low.
// - Dual input mode switch within 100 ms.
// - Low-power release high: class 1 within 100 ms.
// - Low-power pulled low: functional within 300 ms.
// - Dual output mode switch within 100 ms.
// - Override or power-set high: class 1, 100 ms.
// - Override and power-set low: functional, 300 ms.
package sideband_pkg;

  // Flag bank layout.
  localparam int NUM_FLAGS = 8;
  localparam int FLAG_RX_LOSS = 0;
  localparam int FLAG_TX_FAULT = 1;
  localparam int FLAG_DATA_READY = 2;

  // Clock rate.
  localparam int CLK_PERIOD_NS = 8;
  localparam int NS_PER_MS = 1000000;
  localparam int NS_PER_US = 1000;
  localparam int NS_PER_S = 1000000000;

  // Documented limits, in their own units.
  localparam int INIT_MAX_MS = 2000;
  localparam int RESET_MIN_US = 10;
  localparam int ATTN_ASSERT_MAX_MS = 200;
  localparam int ATTN_RELEASE_MAX_US = 500;
  localparam int LOS_ASSERT_MAX_MS = 100;
  localparam int FLAG_ASSERT_MAX_MS = 200;
  localparam int MASK_CHANGE_MAX_MS = 100;
  localparam int SERIAL_READY_MAX_S = 2;
  localparam int FULL_FUNCTION_MAX_S = 2;
  localparam int MODE_CHANGE_MAX_MS = 100;
  localparam int LP_ASSERT_MAX_MS = 100;
  localparam int LP_DEASSERT_MAX_MS = 300;
  localparam int PDOWN_ASSERT_MAX_MS = 100;
  localparam int PDOWN_DEASSERT_MAX_MS = 300;

  // Limits as cycle counts; longest times round down.
  localparam int INIT_MAX_CYC = INIT_MAX_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int RESET_MIN_CYC =
    (RESET_MIN_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_MAX_CYC =
    LP_DEASSERT_MAX_MS * (NS_PER_MS / CLK_PERIOD_NS);

  // Chosen working times, well inside the limits above.
  localparam int INIT_TIME_MS = 1000;
  localparam int WAKE_TIME_MS = 200;
  localparam int INIT_TIME_CYC = INIT_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int WAKE_TIME_CYC = WAKE_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);

  // Counter width covers the longest limit.
  localparam int CNT_W = 28;
  localparam logic [CNT_W-1:0] CNT_ZERO = 28'h0000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 28'h0000001;

  // Values after reset.
  localparam logic [1:0] PIN_RESET_VAL = 2'h1;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 8'h00;

  typedef enum logic [1:0] {st_hold, st_init, st_run} init_e;
  typedef enum logic [1:0] {pwr_low, pwr_wake, pwr_full} power_e;

endpackage : sideband_pkg

// *** verif/host_model.sv ***
`timescale 1ns/100ps
// Host controller: drives the module reset and low-power pins.
module host_model (
  input wire logic clk,
  output logic host_reset_n,
  output logic low_power_request
);
  // Low power is held low from the start so full function is reachable.
  initial begin
    host_reset_n = 1'b1;
    low_power_request = 1'b0;
  end
  // Shorter pulses are not sure to reset, so the full minimum is held.
  task automatic pulse_reset();
    @(posedge clk);
    #1;
    host_reset_n = 1'b0;
    repeat (sideband_pkg::RESET_MIN_CYC) @(posedge clk);
    #1;
    host_reset_n = 1'b1;
  endtask : pulse_reset
  task automatic set_lp(input logic v);
    low_power_request = v;
  endtask : set_lp
endmodule : host_model

// *** verif/mgmt_sideband_chk.sv ***
`timescale 1ns/100ps
// Port-level timing checks, in cycles of the block clock.
module mgmt_sideband_chk #(
  parameter int INIT_CYCLES = 20,
  parameter int WAKE_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_reset_n,
  input wire logic low_power_request,
  input wire logic input_mode_transmit_disable,
  input wire logic output_mode_los,
  input wire logic [sideband_pkg::NUM_FLAGS-1:0] flag_condition,
  input wire logic [sideband_pkg::NUM_FLAGS-1:0] flag_read_clear,
  input wire logic [sideband_pkg::NUM_FLAGS-1:0] flag_mask,
  input wire logic power_override,
  input wire logic power_set,
  input wire logic attention_out_n,
  input wire logic receive_loss_out_n,
  input wire logic transmit_disable,
  input wire logic management_init_state,
  input wire logic serial_bus_ready,
  input wire logic data_not_ready,
  input wire logic [sideband_pkg::NUM_FLAGS-1:0] flags,
  input wire logic low_power_active,
  input wire logic fully_functional
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic want_low;
  int init_run;
  int wake_run;
  assign want_low = power_override | power_set
    | (low_power_request & ~input_mode_transmit_disable);
  // Run lengths; the slack of 8 covers the pin synchroniser lag.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_run <= 0;
      wake_run <= 0;
    end else begin
      init_run <= (management_init_state && host_reset_n) ? init_run + 1 : 0;
      wake_run <= (low_power_active && !want_low) ? wake_run + 1 : 0;
    end
  end
  sequence s_attn_mode;
    !output_mode_los;
  endsequence
  sequence s_los_held;
    output_mode_los && flag_condition[0];
  endsequence
  a_attn_summary: assert property (
    (s_attn_mode[*3] ##0 $stable(flag_mask))
      |-> attention_out_n == !(|(flags & ~flag_mask)))
    else $error("attention differs from masked flags");
  // Two ready samples in a row prove that init was in run when the
  // condition was taken; a single one lags a host reset by a cycle.
  a_flag_set: assert property (
    serial_bus_ready ##1 serial_bus_ready |-> ##1
      ((flags & $past(flag_condition, 2)) == $past(flag_condition, 2)))
    else $error("flag not set two cycles after condition");
  a_clear_read: assert property (
    ((flag_read_clear & ~flag_condition) != 8'h00) |-> ##2
      ((flags & $past(flag_read_clear & ~flag_condition, 2)) == 8'h00))
    else $error("flag not cleared after read");
  a_los_pin: assert property (s_los_held[*4] |-> !receive_loss_out_n)
    else $error("loss pin not low in loss mode");
  a_los_quiet: assert property (
    output_mode_los[*3] |-> attention_out_n)
    else $error("attention driven in loss mode");
  a_transmit_disable_gate: assert property (
    (!input_mode_transmit_disable)[*3] |-> !transmit_disable)
    else $error("transmit disable outside its mode");
  a_power_down: assert property (
    (power_override || power_set) |-> ##2
      (low_power_active && !fully_functional))
    else $error("power bits did not force low power");
  a_wake_bound: assert property (wake_run <= WAKE_CYCLES + 8)
    else $error("wake from low power too slow");
  a_init_bound: assert property (init_run <= INIT_CYCLES + 8)
    else $error("init state lasted too long");
  a_ready_pair: assert property (
    serial_bus_ready == !data_not_ready
      && serial_bus_ready == !management_init_state)
    else $error("ready and not-ready status disagree");
endmodule : mgmt_sideband_chk
bind mgmt_sideband mgmt_sideband_chk #(
  .INIT_CYCLES(INIT_CYCLES),
  .WAKE_CYCLES(WAKE_CYCLES)
) u_chk (.*);

// *** verif/mgmt_sideband_test.sv ***
`timescale 1ns/100ps
// Bench with shortened init and wake counts; inputs move 1 ns after edges.
module mgmt_sideband_test;
  localparam int INIT = 20;
  localparam int WAKE = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic host_reset_n;
  logic low_power_request;
  logic input_mode_transmit_disable = 1'b0;
  logic output_mode_los = 1'b0;
  logic power_override = 1'b0;
  logic power_set = 1'b0;
  logic [7:0] flag_condition = 8'h00;
  logic [7:0] flag_read_clear = 8'h00;
  logic [7:0] flag_mask = 8'h00;
  logic [7:0] flags;
  logic attention_out_n;
  logic receive_loss_out_n;
  logic transmit_disable;
  logic management_init_state;
  logic serial_bus_ready;
  logic data_not_ready;
  logic low_power_active;
  logic fully_functional;
  int err_total = 0;
  int num_checks = 0;
  always #(sideband_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  host_model u_host (
    .clk(clk),
    .host_reset_n(host_reset_n),
    .low_power_request(low_power_request)
  );
  mgmt_sideband #(.INIT_CYCLES(INIT), .WAKE_CYCLES(WAKE)) u_dut (.*);
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [7:0] got,
                     input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk1(input string what, input logic got, input logic exp);
    chk(what, {7'h00, got}, {7'h00, exp});
  endtask : chk1
  // Bounded wait, so a block stuck in init cannot hang the run.
  task automatic wait_ready(input int limit);
    int n;
    n = 0;
    while (serial_bus_ready !== 1'b1 && n < limit) begin
      step(1);
      n++;
    end
    chk1("ready in time", n < limit, 1'b1);
  endtask : wait_ready
  task automatic pulse(input logic [7:0] cond, input logic [7:0] clr);
    flag_condition = cond;
    flag_read_clear = clr;
    step(1);
    flag_condition = 8'h00;
    flag_read_clear = 8'h00;
  endtask : pulse
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence: init, every flag, both pin modes, power, host reset.
  initial begin
    step(10);
    rst_n = 1'b1;
    wait_ready(INIT + 8);
    step(2);
    chk1("data not ready", data_not_ready, 1'b0);
    chk("flags at init", flags, 8'h04);
    chk1("attention at init", attention_out_n, 1'b0);
    pulse(8'h00, 8'h04);
    step(3);
    chk1("attention released", attention_out_n, 1'b1);
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i, 8'h00);
      step(3);
      chk("flag set", flags, 8'h01 << i);
      chk1("attention on flag", attention_out_n, 1'b0);
      flag_mask = 8'h01 << i;
      step(2);
      chk1("attention masked", attention_out_n, 1'b1);
      flag_mask = 8'h00;
      step(2);
      chk1("attention unmasked", attention_out_n, 1'b0);
      pulse(8'h01 << i, 8'h01 << i);
      step(3);
      chk("set beats clear", flags, 8'h01 << i);
      pulse(8'h00, 8'h01 << i);
      step(3);
      chk("flag read clear", flags, 8'h00);
      chk1("attention after clear", attention_out_n, 1'b1);
    end
    output_mode_los = 1'b1;
    flag_condition = 8'h01;
    step(6);
    chk1("loss pin", receive_loss_out_n, 1'b0);
    chk1("attention in loss mode", attention_out_n, 1'b1);
    flag_condition = 8'h00;
    output_mode_los = 1'b0;
    step(6);
    chk1("attention mode back", attention_out_n, 1'b0);
    pulse(8'h00, 8'h01);
    input_mode_transmit_disable = 1'b1;
    u_host.set_lp(1'b1);
    step(6);
    chk1("transmit disable", transmit_disable, 1'b1);
    chk1("power stays full", low_power_active, 1'b0);
    input_mode_transmit_disable = 1'b0;
    step(6);
    chk1("low power by pin", low_power_active, 1'b1);
    chk1("transmit enabled", transmit_disable, 1'b0);
    u_host.set_lp(1'b0);
    step(WAKE + 8);
    chk1("full after pin", fully_functional, 1'b1);
    for (int i = 0; i < 2; i++) begin
      {power_override, power_set} = 2'h1 << i;
      step(3);
      chk1("low power by bit", low_power_active, 1'b1);
      {power_override, power_set} = 2'h0;
      step(WAKE + 4);
      chk1("full after bit", fully_functional, 1'b1);
    end
    u_host.pulse_reset();
    chk1("init during reset", management_init_state, 1'b1);
    wait_ready(INIT + 8);
    step(2);
    chk1("full after reset", fully_functional, 1'b1);
    tally_and_finish();
  end
  // Watchdog, several times the expected run length.
  initial begin
    #(20000 * sideband_pkg::CLK_PERIOD_NS);
    err_total++;
    tally_and_finish();
  end
endmodule : mgmt_sideband_test
